// *** hw/prescaler_pkg.sv ***
package prescaler_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int RATIO_W = 3;
    localparam int LOG_W = 4;
    localparam int FAST_CNT_W = 13;
    localparam int SLOW_CNT_W = 8;

    // register byte addresses
    localparam logic [ADDR_W-1:0] OSC_CTRL_ADDR = 16'hff01;
    localparam logic [ADDR_W-1:0] WIDE_PRESCALE_ADDR = 16'hff10;
    localparam logic [ADDR_W-1:0] BYTE_PRESCALE_ADDR = 16'hff11;
    localparam logic [ADDR_W-1:0] SOURCE_SELECT_ADDR = 16'hff12;
    localparam logic [ADDR_W-1:0] CLKOUT_PRESCALE_ADDR = 16'hff14;
    localparam logic [ADDR_W-1:0] EVENT_GATE_ADDR = 16'hff15;

    // field positions
    localparam int OSC_ON_BIT = 2;
    localparam int T0_RATIO_LSB = 0;
    localparam int T0_EN_BIT = 3;
    localparam int T1_RATIO_LSB = 4;
    localparam int T1_EN_BIT = 7;
    localparam int BYTE_RATIO_LSB = 0;
    localparam int BYTE_EN_BIT = 3;
    localparam int T0_SRC_BIT = 0;
    localparam int T1_SRC_BIT = 1;
    localparam int FAST_OUT_LSB = 0;
    localparam int FAST_OUT_EN_BIT = 3;
    localparam int SLOW_OUT_LSB = 4;
    localparam int SLOW_OUT_EN_BIT = 7;
    localparam int EV0_BIT = 0;
    localparam int EV1_BIT = 1;

    localparam logic [RATIO_W-1:0] RATIO_RESET = 3'h0;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

    // log2 of the divisor; a timer divisor N needs 2N oscillator edges
    function automatic logic [LOG_W-1:0] fastTimerLog2(input logic [RATIO_W-1:0] code);
        case (code)
            3'h7: fastTimerLog2 = 4'hc;
            3'h6: fastTimerLog2 = 4'ha;
            3'h5: fastTimerLog2 = 4'h8;
            3'h4: fastTimerLog2 = 4'h7;
            3'h3: fastTimerLog2 = 4'h6;
            3'h2: fastTimerLog2 = 4'h5;
            3'h1: fastTimerLog2 = 4'h3;
            default: fastTimerLog2 = 4'h1;
        endcase
    endfunction

    function automatic logic [LOG_W-1:0] slowLog2(input logic [RATIO_W-1:0] code);
        slowLog2 = {1'b0, code};
    endfunction

    function automatic logic [LOG_W-1:0] byteTimerLog2(input logic [RATIO_W-1:0] code);
        byteTimerLog2 = {1'b0, code} + 4'h1;
    endfunction

endpackage

// *** hw/prescale_tap_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface prescale_tap_if #(parameter int CNT_W = 8, parameter int LOG_W = 4);
    logic edgeTick;
    logic [CNT_W-1:0] count;
    logic [LOG_W-1:0] log2;
    logic divTick;
    logic halfTick;

    modport tap (input edgeTick, input count, input log2, output divTick, output halfTick);
    modport ctrl (output edgeTick, output count, output log2, input divTick, input halfTick);
endinterface
`default_nettype wire

// *** hw/edge_counter.sv ***
`timescale 1ns/1ps
`default_nettype none
module edge_counter #(
    parameter int CNT_W = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // oscillator edges
    input wire logic edgeTick,
    output logic [CNT_W-1:0] count
);
    // refuse counter widths the taps cannot serve
    if (CNT_W < 2 || CNT_W > 16) begin : gBadWidth
        $error("edge_counter width out of range");
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            count <= '0;
        end else if (edgeTick) begin
            count <= count + 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** hw/prescale_tap.sv ***
`timescale 1ns/1ps
`default_nettype none
module prescale_tap #(
    parameter int CNT_W = 8,
    parameter int LOG_W = 4
) (
    prescale_tap_if.tap tap
);
    logic [CNT_W-1:0] fullMask;
    logic [CNT_W-1:0] halfMask;

    if (CNT_W > (1 << LOG_W)) begin : gBadWidth
        $error("prescale_tap counter wider than log2 field can address");
    end

    // divTick every 2^(log2+1) edges, halfTick every 2^log2 edges
    always_comb begin
        fullMask = '0;
        halfMask = '0;
        for (int i = 0; i < CNT_W; i++) begin
            fullMask[i] = (LOG_W'(i) <= tap.log2);
            halfMask[i] = (LOG_W'(i) < tap.log2);
        end
        tap.divTick = tap.edgeTick && ((tap.count & fullMask) == fullMask);
        tap.halfTick = tap.edgeTick && ((tap.count & halfMask) == halfMask);
    end
endmodule
`default_nettype wire

// *** hw/timer_clock_prescaler.sv ***
// Functional notes
// RULE_01: timer 0 divides its source by 4096,1024,256,128,64,32,8,2 (fast) or 128..1 (slow) per a 3-bit field resetting to 0.
// RULE_02: timer 0 receives its divided clock only while its enable bit, reset to 0, is set.
// RULE_03: timer 1 takes the slow oscillator when its source bit is 1, else the fast one; reset 0.
// RULE_04: timer 0 takes the slow oscillator when its source bit is 1, else the fast one; reset 0.
// RULE_05: the byte timer divides the fast oscillator by 256..2 per a 3-bit field resetting to 0.
// RULE_06: the byte timer receives its clock only while its enable bit, reset to 0, is set.
// RULE_07: the fast oscillator runs while its control bit is 1 and stops at 0; reads return the bit.
// RULE_08: reset clears the fast oscillator control bit, so the fast oscillator starts off.
// RULE_09: software sets the fast oscillator bit before relying on any fast-derived clock.
// RULE_10: timer 1 has its own 3-bit ratio field and enable bit like timer 0, both reset to 0.
// RULE_11: the slow clock pin carries the slow oscillator divided by 128..1, gated by an enable; reset 0.
// RULE_12: the fast clock pin carries the fast oscillator divided by 128..1, gated by an enable; reset 0.
// RULE_13: each event input pin reaches its wide timer only while its own enable bit, reset 0, is set.
// RULE_14: unused register bits read as 0 and ignore writes.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module timer_clock_prescaler
    import prescaler_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [DATA_W-1:0] regRdData,
    // oscillators: one pulse per oscillator edge
    input wire logic slowOscillatorEdge,
    input wire logic fastOscillatorEdge,
    output logic fastOscOn,
    // timer clock enables
    output logic timer0Tick,
    output logic timer1Tick,
    output logic byteTimerTick,
    // event counter inputs
    input wire logic event0ClockPin,
    input wire logic event1ClockPin,
    output logic event0Clock,
    output logic event1Clock,
    // clock output pins
    output logic slowClockPin,
    output logic fastClockPin
);
    // control fields
    logic [RATIO_W-1:0] timer0Ratio;
    logic [RATIO_W-1:0] timer1Ratio;
    logic [RATIO_W-1:0] byteTimerRatio;
    logic [RATIO_W-1:0] slowOutRatio;
    logic [RATIO_W-1:0] fastOutRatio;
    logic timer0ClockEnable;
    logic timer1ClockEnable;
    logic byteTimerClockEnable;
    logic timer0SourceSelect;
    logic timer1SourceSelect;
    logic slowOutEnable;
    logic fastOutEnable;
    logic event0InputEnable;
    logic event1InputEnable;

    logic fastEdge;
    logic [FAST_CNT_W-1:0] fastCount;
    logic [SLOW_CNT_W-1:0] slowCount;
    logic [DATA_W-1:0] next_regRdData;

    prescale_tap_if #(.CNT_W(FAST_CNT_W), .LOG_W(LOG_W)) t0FastTap();
    prescale_tap_if #(.CNT_W(SLOW_CNT_W), .LOG_W(LOG_W)) t0SlowTap();
    prescale_tap_if #(.CNT_W(FAST_CNT_W), .LOG_W(LOG_W)) t1FastTap();
    prescale_tap_if #(.CNT_W(SLOW_CNT_W), .LOG_W(LOG_W)) t1SlowTap();
    prescale_tap_if #(.CNT_W(FAST_CNT_W), .LOG_W(LOG_W)) byteTap();
    prescale_tap_if #(.CNT_W(SLOW_CNT_W), .LOG_W(LOG_W)) slowOutTap();
    prescale_tap_if #(.CNT_W(FAST_CNT_W), .LOG_W(LOG_W)) fastOutTap();

    // fast oscillator edges are dropped while it is switched off
    assign fastEdge = fastOscillatorEdge && fastOscOn; // RULE_07

    edge_counter #(.CNT_W(FAST_CNT_W)) fastCounter (
        .ref_clk(ref_clk),
        .srst(srst),
        .edgeTick(fastEdge),
        .count(fastCount)
    );

    edge_counter #(.CNT_W(SLOW_CNT_W)) slowCounter (
        .ref_clk(ref_clk),
        .srst(srst),
        .edgeTick(slowOscillatorEdge),
        .count(slowCount)
    );

    // tap wiring
    assign t0FastTap.edgeTick = fastEdge;
    assign t0FastTap.count = fastCount;
    assign t0FastTap.log2 = fastTimerLog2(timer0Ratio); // RULE_01
    assign t0SlowTap.edgeTick = slowOscillatorEdge;
    assign t0SlowTap.count = slowCount;
    assign t0SlowTap.log2 = slowLog2(timer0Ratio); // RULE_01
    assign t1FastTap.edgeTick = fastEdge;
    assign t1FastTap.count = fastCount;
    assign t1FastTap.log2 = fastTimerLog2(timer1Ratio); // RULE_10
    assign t1SlowTap.edgeTick = slowOscillatorEdge;
    assign t1SlowTap.count = slowCount;
    assign t1SlowTap.log2 = slowLog2(timer1Ratio); // RULE_10
    assign byteTap.edgeTick = fastEdge;
    assign byteTap.count = fastCount;
    assign byteTap.log2 = byteTimerLog2(byteTimerRatio); // RULE_05
    assign slowOutTap.edgeTick = slowOscillatorEdge;
    assign slowOutTap.count = slowCount;
    assign slowOutTap.log2 = slowLog2(slowOutRatio); // RULE_11
    assign fastOutTap.edgeTick = fastEdge;
    assign fastOutTap.count = fastCount;
    assign fastOutTap.log2 = slowLog2(fastOutRatio); // RULE_12

    prescale_tap #(.CNT_W(FAST_CNT_W), .LOG_W(LOG_W)) t0FastDiv (.tap(t0FastTap.tap));
    prescale_tap #(.CNT_W(SLOW_CNT_W), .LOG_W(LOG_W)) t0SlowDiv (.tap(t0SlowTap.tap));
    prescale_tap #(.CNT_W(FAST_CNT_W), .LOG_W(LOG_W)) t1FastDiv (.tap(t1FastTap.tap));
    prescale_tap #(.CNT_W(SLOW_CNT_W), .LOG_W(LOG_W)) t1SlowDiv (.tap(t1SlowTap.tap));
    prescale_tap #(.CNT_W(FAST_CNT_W), .LOG_W(LOG_W)) byteDiv (.tap(byteTap.tap));
    prescale_tap #(.CNT_W(SLOW_CNT_W), .LOG_W(LOG_W)) slowOutDiv (.tap(slowOutTap.tap));
    prescale_tap #(.CNT_W(FAST_CNT_W), .LOG_W(LOG_W)) fastOutDiv (.tap(fastOutTap.tap));

    // oscillator control register: only the fast oscillator bit lives here
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            fastOscOn <= 1'b0; // RULE_08
        end else if (regWrite && regAddr == OSC_CTRL_ADDR) begin
            fastOscOn <= regWrData[OSC_ON_BIT]; // RULE_07
        end
    end

    // wide timer ratio and enables
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            timer0Ratio <= RATIO_RESET; // RULE_01
            timer1Ratio <= RATIO_RESET; // RULE_10
            timer0ClockEnable <= 1'b0; // RULE_02
            timer1ClockEnable <= 1'b0; // RULE_10
        end else if (regWrite && regAddr == WIDE_PRESCALE_ADDR) begin
            timer0Ratio <= regWrData[T0_RATIO_LSB +: RATIO_W];
            timer1Ratio <= regWrData[T1_RATIO_LSB +: RATIO_W];
            timer0ClockEnable <= regWrData[T0_EN_BIT];
            timer1ClockEnable <= regWrData[T1_EN_BIT];
        end
    end

    // byte timer ratio and enable
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            byteTimerRatio <= RATIO_RESET; // RULE_05
            byteTimerClockEnable <= 1'b0; // RULE_06
        end else if (regWrite && regAddr == BYTE_PRESCALE_ADDR) begin
            byteTimerRatio <= regWrData[BYTE_RATIO_LSB +: RATIO_W];
            byteTimerClockEnable <= regWrData[BYTE_EN_BIT];
        end
    end

    // wide timer source select
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            timer0SourceSelect <= 1'b0; // RULE_04
            timer1SourceSelect <= 1'b0; // RULE_03
        end else if (regWrite && regAddr == SOURCE_SELECT_ADDR) begin
            timer0SourceSelect <= regWrData[T0_SRC_BIT];
            timer1SourceSelect <= regWrData[T1_SRC_BIT];
        end
    end

    // clock output ratios and enables
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            slowOutRatio <= RATIO_RESET; // RULE_11
            fastOutRatio <= RATIO_RESET; // RULE_12
            slowOutEnable <= 1'b0;
            fastOutEnable <= 1'b0;
        end else if (regWrite && regAddr == CLKOUT_PRESCALE_ADDR) begin
            slowOutRatio <= regWrData[SLOW_OUT_LSB +: RATIO_W];
            fastOutRatio <= regWrData[FAST_OUT_LSB +: RATIO_W];
            slowOutEnable <= regWrData[SLOW_OUT_EN_BIT];
            fastOutEnable <= regWrData[FAST_OUT_EN_BIT];
        end
    end

    // event input gates
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            event0InputEnable <= 1'b0; // RULE_13
            event1InputEnable <= 1'b0; // RULE_13
        end else if (regWrite && regAddr == EVENT_GATE_ADDR) begin
            event0InputEnable <= regWrData[EV0_BIT];
            event1InputEnable <= regWrData[EV1_BIT];
        end
    end

    // read mux; unused bits and unmapped addresses read zero
    always_comb begin
        next_regRdData = READ_ZERO; // RULE_14
        case (regAddr)
            OSC_CTRL_ADDR: begin
                next_regRdData[OSC_ON_BIT] = fastOscOn; // RULE_07
            end
            WIDE_PRESCALE_ADDR: begin
                next_regRdData[T0_RATIO_LSB +: RATIO_W] = timer0Ratio;
                next_regRdData[T1_RATIO_LSB +: RATIO_W] = timer1Ratio;
                next_regRdData[T0_EN_BIT] = timer0ClockEnable;
                next_regRdData[T1_EN_BIT] = timer1ClockEnable;
            end
            BYTE_PRESCALE_ADDR: begin
                next_regRdData[BYTE_RATIO_LSB +: RATIO_W] = byteTimerRatio;
                next_regRdData[BYTE_EN_BIT] = byteTimerClockEnable;
            end
            SOURCE_SELECT_ADDR: begin
                next_regRdData[T0_SRC_BIT] = timer0SourceSelect;
                next_regRdData[T1_SRC_BIT] = timer1SourceSelect;
            end
            CLKOUT_PRESCALE_ADDR: begin
                next_regRdData[SLOW_OUT_LSB +: RATIO_W] = slowOutRatio;
                next_regRdData[FAST_OUT_LSB +: RATIO_W] = fastOutRatio;
                next_regRdData[SLOW_OUT_EN_BIT] = slowOutEnable;
                next_regRdData[FAST_OUT_EN_BIT] = fastOutEnable;
            end
            EVENT_GATE_ADDR: begin
                next_regRdData[EV0_BIT] = event0InputEnable;
                next_regRdData[EV1_BIT] = event1InputEnable;
            end
            default: begin
                next_regRdData = READ_ZERO;
            end
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            regRdData <= READ_ZERO;
        end else if (regRead) begin
            regRdData <= next_regRdData;
        end else begin
            regRdData <= READ_ZERO;
        end
    end

    // timer clock enables: source select then gate
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            timer0Tick <= 1'b0;
            timer1Tick <= 1'b0;
            byteTimerTick <= 1'b0;
        end else begin
            timer0Tick <= timer0ClockEnable && // RULE_02
                (timer0SourceSelect ? t0SlowTap.divTick : t0FastTap.divTick); // RULE_04
            timer1Tick <= timer1ClockEnable && // RULE_10
                (timer1SourceSelect ? t1SlowTap.divTick : t1FastTap.divTick); // RULE_03
            byteTimerTick <= byteTimerClockEnable && byteTap.divTick; // RULE_06
        end
    end

    // event clocks pass as levels while enabled, low otherwise
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            event0Clock <= 1'b0;
            event1Clock <= 1'b0;
        end else begin
            event0Clock <= event0InputEnable && event0ClockPin; // RULE_13
            event1Clock <= event1InputEnable && event1ClockPin; // RULE_13
        end
    end

    // clock pins toggle every N oscillator edges, giving fosc/N; held low when off
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            slowClockPin <= 1'b0;
        end else if (!slowOutEnable) begin
            slowClockPin <= 1'b0;
        end else if (slowOutTap.halfTick) begin
            slowClockPin <= !slowClockPin; // RULE_11
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            fastClockPin <= 1'b0;
        end else if (!fastOutEnable) begin
            fastClockPin <= 1'b0;
        end else if (fastOutTap.halfTick) begin
            fastClockPin <= !fastClockPin; // RULE_12
        end
    end
endmodule
`default_nettype wire

// *** testbench/osc_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module osc_partner #(
    parameter int SLOW_P = 3,
    parameter int FAST_P = 2
) (
    // clock
    input wire logic ref_clk,
    // oscillators
    input wire logic fastOscOn,
    output logic slowOscillatorEdge,
    output logic fastOscillatorEdge,
    // event pins
    output logic event0ClockPin,
    output logic event1ClockPin
);
    int cnt = 0;
    initial begin
        slowOscillatorEdge = 1'b0;
        fastOscillatorEdge = 1'b0;
        event0ClockPin = 1'b0;
        event1ClockPin = 1'b0;
    end
    always @(posedge ref_clk) begin
        cnt <= cnt + 1;
        slowOscillatorEdge <= (cnt % SLOW_P == 0);
        // a stopped oscillator gives no edges
        fastOscillatorEdge <= (fastOscOn === 1'b1) && (cnt % FAST_P == 0);
        event0ClockPin <= cnt[2];
        event1ClockPin <= cnt[3] ^ cnt[0];
    end
endmodule
`default_nettype wire

// *** testbench/timer_clock_prescaler_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module timer_clock_prescaler_sva
    import prescaler_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [DATA_W-1:0] regRdData,
    // outputs and event input pins
    input wire logic fastOscOn,
    input wire logic timer0Tick,
    input wire logic byteTimerTick,
    input wire logic event0ClockPin,
    input wire logic event1ClockPin,
    input wire logic event0Clock,
    input wire logic event1Clock,
    input wire logic slowClockPin,
    input wire logic fastClockPin
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic wOsc, wWide, wByte, wOut, wEv, wSrc, known;
    // a source switch may put a slow tick right next to a fast one
    assign wSrc = regWrite && regAddr == SOURCE_SELECT_ADDR;
    assign wOsc = regWrite && regAddr == OSC_CTRL_ADDR;
    assign wWide = regWrite && regAddr == WIDE_PRESCALE_ADDR;
    assign wByte = regWrite && regAddr == BYTE_PRESCALE_ADDR;
    assign wOut = regWrite && regAddr == CLKOUT_PRESCALE_ADDR;
    assign wEv = regWrite && regAddr == EVENT_GATE_ADDR;
    assign known = regAddr inside {OSC_CTRL_ADDR, WIDE_PRESCALE_ADDR, BYTE_PRESCALE_ADDR,
        SOURCE_SELECT_ADDR, CLKOUT_PRESCALE_ADDR, EVENT_GATE_ADDR};
    read_idle_a: assert property (!$past(regRead) |-> regRdData == READ_ZERO)
        else $error("read data outside read slot");
    bad_addr_a: assert property (regRead && !known |=> regRdData == READ_ZERO)
        else $error("unmapped read not zero");
    osc_write_a: assert property (wOsc |=> fastOscOn == $past(regWrData[OSC_ON_BIT]))
        else $error("osc bit not written");
    osc_hold_a: assert property (!wOsc |=> $stable(fastOscOn))
        else $error("osc bit changed");
    osc_read_a: assert property (regRead && regAddr == OSC_CTRL_ADDR
        |=> regRdData == {5'h00, $past(fastOscOn), 2'h0}) else $error("osc read");
    fast_off_a: assert property (!fastOscOn [*3] |-> !byteTimerTick)
        else $error("tick with fast osc off");
    t0_off_a: assert property (wWide && !regWrData[T0_EN_BIT] |=> ##1 !timer0Tick)
        else $error("timer0 tick while off");
    byte_off_a: assert property (wByte && !regWrData[BYTE_EN_BIT] |=> ##1 !byteTimerTick)
        else $error("byte tick while off");
    slow_pin_off_a: assert property (wOut && !regWrData[SLOW_OUT_EN_BIT] |=> ##1 !slowClockPin)
        else $error("slow pin while off");
    fast_pin_off_a: assert property (wOut && !regWrData[FAST_OUT_EN_BIT] |=> ##1 !fastClockPin)
        else $error("fast pin while off");
    ev_off_a: assert property (wEv && !regWrData[EV0_BIT] |=> ##1 !event0Clock)
        else $error("event0 while off");
    ev_gate_a: assert property ((event0Clock |-> $past(event0ClockPin))
        and (event1Clock |-> $past(event1ClockPin))) else $error("event without pin");
    tick_pulse_a: assert property (timer0Tick && !$past(wSrc) |=> !timer0Tick)
        else $error("tick too long");
endmodule
bind timer_clock_prescaler timer_clock_prescaler_sva timer_clock_prescaler_sva_inst (.ref_clk,
    .srst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .fastOscOn, .timer0Tick,
    .byteTimerTick, .event0ClockPin, .event1ClockPin, .event0Clock, .event1Clock,
    .slowClockPin, .fastClockPin);
`default_nettype wire

// *** testbench/timer_clock_prescaler_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
    $display("mismatch %0t got %h exp %h", $time, a, b); end end
module timer_clock_prescaler_tb_top
    import prescaler_pkg::*;
;
    localparam int SLOW_P = 3;
    localparam int FAST_P = 2;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWrData = '0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [DATA_W-1:0] regRdData;
    logic slowOscillatorEdge, fastOscillatorEdge, fastOscOn;
    logic timer0Tick, timer1Tick, byteTimerTick;
    logic event0ClockPin, event1ClockPin, event0Clock, event1Clock;
    logic slowClockPin, fastClockPin;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    int i, c;
    logic [31:0] seed = 32'ha9d9;
    logic [7:0] shadow [32];
    int fastDiv [8] = '{2, 8, 32, 64, 128, 256, 1024, 4096};
    logic [15:0] addrs [8] = '{16'hff01, 16'hff10, 16'hff11, 16'hff12, 16'hff14, 16'hff15,
        16'hff00, 16'hff13};
    timer_clock_prescaler timer_clock_prescaler_inst (.ref_clk, .srst, .regAddr, .regWrData,
        .regWrite, .regRead, .regRdData, .slowOscillatorEdge, .fastOscillatorEdge, .fastOscOn,
        .timer0Tick, .timer1Tick, .byteTimerTick, .event0ClockPin, .event1ClockPin,
        .event0Clock, .event1Clock, .slowClockPin, .fastClockPin);
    osc_partner #(.SLOW_P(SLOW_P), .FAST_P(FAST_P)) osc_partner_inst (.ref_clk, .fastOscOn,
        .slowOscillatorEdge, .fastOscillatorEdge, .event0ClockPin, .event1ClockPin);
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic complete_run();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 90000) begin
            errors++;
            complete_run();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // implemented bits of each register
    function automatic logic [7:0] mask(input logic [15:0] a);
        case (a)
            OSC_CTRL_ADDR: mask = 8'h04;
            WIDE_PRESCALE_ADDR, CLKOUT_PRESCALE_ADDR: mask = 8'hff;
            BYTE_PRESCALE_ADDR: mask = 8'h0f;
            SOURCE_SELECT_ADDR, EVENT_GATE_ADDR: mask = 8'h03;
            default: mask = 8'h00;
        endcase
    endfunction
    function automatic logic probe(input int s);
        case (s)
            0: probe = timer0Tick;
            1: probe = timer1Tick;
            2: probe = byteTimerTick;
            3: probe = slowClockPin;
            default: probe = fastClockPin;
        endcase
    endfunction
    task automatic op(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regWrite <= w;
        regRead <= r;
        regAddr <= a;
        regWrData <= d;
        if (w)
            shadow[a[4:0]] = d & mask(a);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        op(1'b1, 1'b0, a, d);
    endtask
    task automatic idle();
        @(posedge ref_clk);
        regWrite <= 1'b0;
        regRead <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        op(1'b0, 1'b1, a, 8'h00);
        @(posedge ref_clk);
        regRead <= 1'b0;
        @(negedge ref_clk);
        `CHK(regRdData, shadow[a[4:0]])
    endtask
    task automatic regCheck();
        int k;
        for (k = 0; k < 8; k++)
            rd(addrs[k]);
    endtask
    task automatic doReset();
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        shadow = '{default: 8'h00};
    endtask
    // period between two rising edges of the probed output
    task automatic meas(input int s, input int exp);
        int n, cnt, k;
        logic p, cur;
        n = 0;
        cnt = 0;
        p = 1'b1;
        for (k = 0; k < 40000 && n < 2; k++) begin
            @(negedge ref_clk);
            cur = probe(s);
            if (cur && !p) begin
                if (n == 1)
                    `CHK(cnt, exp)
                n++;
                cnt = 0;
            end
            cnt++;
            p = cur;
        end
        `CHK(n, 2)
    endtask
    task automatic evCheck(input logic en);
        logic p0, p1;
        int k;
        wr(EVENT_GATE_ADDR, {6'h00, en, en});
        idle();
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        for (k = 0; k < 30; k++) begin
            p0 = event0ClockPin;
            p1 = event1ClockPin;
            @(negedge ref_clk);
            `CHK(event0Clock, p0 & en)
            `CHK(event1Clock, p1 & en)
        end
    endtask
    initial begin
        doReset();
        regCheck();
        for (i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            wr(addrs[i % 8], seed[7:0]);
            if (i % 3 == 2)
                regCheck();
        end
        regCheck();
        doReset();
        regCheck();
        wr(OSC_CTRL_ADDR, 8'h04);
        wr(SOURCE_SELECT_ADDR, 8'h02);
        for (c = 0; c < 8; c++) begin
            wr(WIDE_PRESCALE_ADDR, {1'b1, c[2:0], 1'b1, c[2:0]});
            wr(BYTE_PRESCALE_ADDR, {5'h01, c[2:0]});
            wr(CLKOUT_PRESCALE_ADDR, {1'b1, c[2:0], 1'b1, c[2:0]});
            idle();
            meas(0, 2 * FAST_P * fastDiv[c]);
            meas(1, 2 * SLOW_P * (1 << c));
            meas(2, 2 * FAST_P * (2 << c));
            meas(3, 2 * SLOW_P * (1 << c));
            meas(4, 2 * FAST_P * (1 << c));
        end
        wr(SOURCE_SELECT_ADDR, 8'h01);
        wr(WIDE_PRESCALE_ADDR, 8'h88);
        idle();
        meas(0, 2 * SLOW_P);
        meas(1, 2 * FAST_P * 2);
        evCheck(1'b1);
        evCheck(1'b0);
        wr(BYTE_PRESCALE_ADDR, 8'h08);
        wr(OSC_CTRL_ADDR, 8'h00);
        idle();
        repeat (3) @(posedge ref_clk);
        for (i = 0; i < 50; i++) begin
            @(negedge ref_clk);
            `CHK(byteTimerTick, 1'b0)
        end
        complete_run();
    end
endmodule
`default_nettype wire
